// ---- strap_latch_params.svh ----
`ifndef STRAP_LATCH_PARAMS_SVH
`define STRAP_LATCH_PARAMS_SVH

// Register offsets (byte addresses)
`define STRAP_STATUS_OFF 8'h00
`define STRAP_CONFIG_OFF 8'h04
`define STRAP_EFFECT_OFF 8'h08

// Strap bit positions in the status register and on the pin vectors
`define STRAP_LDO_BIT 0
`define STRAP_BOOT_BIT 1
`define STRAP_QUAL_BIT 2
`define STRAP_LOG_BIT 3
`define STRAP_SDIO_BIT 4
`define STRAP_COUNT 5

// Internal pull direction per strap, 1 = pull-up; also the reset value of the latches
`define STRAP_PULL_UP_MASK 5'h1A

// Configuration register fields
`define CFG_LDO_OVR_EN_BIT 0
`define CFG_LDO_1V8_BIT 1
`define CFG_SDIO_OVR_EN_BIT 2
`define CFG_SDIO_SAMPLE_BIT 3
`define CFG_SDIO_OUTPUT_BIT 4
`define CFG_WIDTH 5
`define CFG_RESET 5'h00

// Effective-configuration register fields
`define EFF_FLASH_BIT 0
`define EFF_BOOT_LSB 1
`define EFF_LOG_BIT 3
`define EFF_SAMPLE_BIT 4
`define EFF_OUTPUT_BIT 5
`define EFF_VALID_BIT 6

`endif

// ---- strap_latch_pkg.sv ----
`default_nettype none

package strap_latch_pkg;

  typedef enum logic [1:0] {
    BOOT_SPI,
    BOOT_DOWNLOAD,
    BOOT_UNDEFINED
  } boot_mode_type;

  typedef enum logic {
    PH_TRACK,
    PH_HELD
  } phase_type;

endpackage

`default_nettype wire

// ---- strap_pad_cell.sv ----
`timescale 1ns/1ns
`default_nettype none

module strap_pad_cell #(
  parameter logic PULL_UP = 1'h0
) (
  input wire logic clk,        // System clock
  input wire logic srst,       // Synchronous reset, active high
  input wire logic track,      // Latch transparent, pad held for strapping
  input wire logic pin_in,     // Resolved pad level
  input wire logic func_out,   // Normal-function output value
  input wire logic func_oe,    // Normal-function output enable, active high
  output logic pin_out,        // Pad output value
  output logic pin_oe_n,       // Pad output enable, low while driving
  output logic pull_en,        // Internal weak pull applied
  output logic func_in,        // Pad level seen by the normal function
  output logic strap_bit       // Latched strap value
);

  // Latch follows the pad while tracking and freezes on the last tracking edge
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_bit <= PULL_UP;
    end else if (track) begin
      strap_bit <= pin_in;
    end
  end

  // Pad stays undriven with its weak pull until the straps are held
  always_ff @(posedge clk) begin
    if (srst) begin
      pull_en <= 1'h1;
      pin_oe_n <= 1'h1;
      pin_out <= 1'h0;
      func_in <= 1'h0;
    end else if (track) begin
      pull_en <= 1'h1;
      pin_oe_n <= 1'h1;
      pin_out <= 1'h0;
      func_in <= 1'h0;
    end else begin
      pull_en <= 1'h0;
      pin_oe_n <= ~func_oe;
      pin_out <= func_out;
      func_in <= pin_in;
    end
  end

endmodule

`default_nettype wire

// ---- reset_strap_config_latch.sv ----
// Functional notes
// - Five strap inputs latched and readable as five status register bits.
// - Straps sampled on reset release and held until the next reset (EN low or SRST).
// - During reset each strap pad has its weak pull; floating reads default.
// - After capture pads return to normal function; latched values unaffected.
// - LDO strap: 0 selects 3.3 V flash supply, 1 selects 1.8 V.
// - Boot-select 1 gives SPI boot; boot-select 0 and qualify 0 give download.
// - Log strap 1 enables boot log on transmit line, 0 keeps it silent.
// - Log and SDIO-edge straps pick SDIO sampling and output edges.
// - Firmware may override flash voltage and SDIO timing after boot.
`timescale 1ns/1ns
`default_nettype none
`include "strap_latch_params.svh"

module reset_strap_config_latch
  import strap_latch_pkg::*;
(
  input wire logic CLK,                 // 100 MHz system clock
  input wire logic SRST,                // Synchronous reset, active high
  input wire logic EN,                  // Module enable, active high
  input wire logic [7:0] ADDR,          // Register address
  input wire logic [31:0] WDATA,        // Register write data
  input wire logic WR,                  // Write strobe
  input wire logic RD,                  // Read strobe
  output logic [31:0] RDATA,            // Read data, cycle after RD
  input wire logic [4:0] STRAP_PIN_IN,  // Strap pad levels
  output logic [4:0] STRAP_PIN_OUT,     // Strap pad output values
  output logic [4:0] STRAP_PIN_OE_N,    // Strap pad output enables, low drives
  output logic [4:0] STRAP_PULL_EN,     // Weak pull enables
  input wire logic [4:0] FUNC_OUT,      // Normal-function outputs to pads
  input wire logic [4:0] FUNC_OE,       // Normal-function output enables
  output logic [4:0] FUNC_IN,           // Pad levels to normal functions
  output logic STRAPS_VALID,            // Straps captured and held
  output logic FLASH_VDD_1V8,           // Flash supply 1.8 V when high, else 3.3 V
  output boot_mode_type BOOT_MODE,      // Decoded boot source
  output logic BOOT_LOG_EN,             // Boot log enabled on transmit line
  output logic SDIO_SAMPLE_RISE,        // SDIO slave samples on rising edge
  output logic SDIO_OUTPUT_RISE         // SDIO slave drives on rising edge
);

  phase_type phase_reg;
  phase_type phase_next;
  logic [4:0] strap_bits;
  logic [`CFG_WIDTH-1:0] cfg_reg;
  logic track;
  // Latch reset values double as the pad pull directions
  localparam logic [4:0] PULL_MASK = `STRAP_PULL_UP_MASK;

  function automatic boot_mode_type decode_boot(input logic sel, input logic qual);
    if (sel) begin
      return BOOT_SPI;
    end else if (!qual) begin
      return BOOT_DOWNLOAD;
    end else begin
      return BOOT_UNDEFINED;
    end
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                           input logic [4:0] straps,
                                           input logic [`CFG_WIDTH-1:0] cfg,
                                           input logic [6:0] eff);
    case (addr)
      `STRAP_STATUS_OFF: read_mux = {27'h0000000, straps};
      `STRAP_CONFIG_OFF: read_mux = {27'h0000000, cfg};
      `STRAP_EFFECT_OFF: read_mux = {25'h0000000, eff};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  // Capture phase: a new low on the enable reopens the latches
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_TRACK: if (EN) phase_next = PH_HELD;
      PH_HELD: if (!EN) phase_next = PH_TRACK;
      default: phase_next = PH_TRACK;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      phase_reg <= PH_TRACK;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign track = (phase_reg == PH_TRACK);

  genvar gi;
  generate
    for (gi = 0; gi < `STRAP_COUNT; gi++) begin : g_pad
      strap_pad_cell #(
        .PULL_UP(PULL_MASK[gi])
      ) u_pad (
        .clk(CLK),
        .srst(SRST),
        .track(track),
        .pin_in(STRAP_PIN_IN[gi]),
        .func_out(FUNC_OUT[gi]),
        .func_oe(FUNC_OE[gi]),
        .pin_out(STRAP_PIN_OUT[gi]),
        .pin_oe_n(STRAP_PIN_OE_N[gi]),
        .pull_en(STRAP_PULL_EN[gi]),
        .func_in(FUNC_IN[gi]),
        .strap_bit(strap_bits[gi])
      );
    end
  endgenerate

  // Overrides are only taken once booted; a re-entry into reset drops them
  always_ff @(posedge CLK) begin
    if (SRST || track) begin
      cfg_reg <= `CFG_RESET;
    end else if (WR && ADDR == `STRAP_CONFIG_OFF) begin
      cfg_reg <= WDATA[`CFG_WIDTH-1:0];
    end
  end

  // Effective boot configuration
  always_ff @(posedge CLK) begin
    if (SRST) begin
      STRAPS_VALID <= 1'h0;
      FLASH_VDD_1V8 <= 1'h0;
      BOOT_MODE <= BOOT_SPI;
      BOOT_LOG_EN <= 1'h1;
      SDIO_SAMPLE_RISE <= 1'h1;
      SDIO_OUTPUT_RISE <= 1'h1;
    end else begin
      STRAPS_VALID <= (phase_reg == PH_HELD);
      FLASH_VDD_1V8 <= cfg_reg[`CFG_LDO_OVR_EN_BIT] ? cfg_reg[`CFG_LDO_1V8_BIT]
                                                    : strap_bits[`STRAP_LDO_BIT];
      BOOT_MODE <= decode_boot(strap_bits[`STRAP_BOOT_BIT],
                               strap_bits[`STRAP_QUAL_BIT]);
      BOOT_LOG_EN <= strap_bits[`STRAP_LOG_BIT];
      SDIO_SAMPLE_RISE <= cfg_reg[`CFG_SDIO_OVR_EN_BIT] ? cfg_reg[`CFG_SDIO_SAMPLE_BIT]
                                                       : strap_bits[`STRAP_LOG_BIT];
      SDIO_OUTPUT_RISE <= cfg_reg[`CFG_SDIO_OVR_EN_BIT] ? cfg_reg[`CFG_SDIO_OUTPUT_BIT]
                                                       : strap_bits[`STRAP_SDIO_BIT];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      RDATA <= read_mux(ADDR, strap_bits, cfg_reg,
                        {STRAPS_VALID, SDIO_OUTPUT_RISE, SDIO_SAMPLE_RISE, BOOT_LOG_EN,
                         BOOT_MODE, FLASH_VDD_1V8});
    end else begin
      RDATA <= 32'h00000000;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_held_two;
    (phase_reg == PH_HELD) ##1 (phase_reg == PH_HELD);
  endsequence

  sequence s_track_then_rise;
    (phase_reg == PH_TRACK && !EN) ##1 (phase_reg == PH_TRACK && EN);
  endsequence

  a_hold_stable: assert property ((phase_reg == PH_HELD && EN) |=> $stable(strap_bits))
    else $error("strap latches changed while held");

  a_capture_edge: assert property (s_track_then_rise |=> (phase_reg == PH_HELD &&
                                   strap_bits == $past(STRAP_PIN_IN)))
    else $error("straps not captured on enable rise");

  a_track_pull: assert property ((phase_reg == PH_TRACK) [*2] |->
                                 (STRAP_PULL_EN == 5'h1F && STRAP_PIN_OE_N == 5'h1F))
    else $error("strap pads not pulled while tracking");

  a_func_return: assert property (s_held_two |-> (STRAP_PULL_EN == 5'h00 &&
                                  STRAP_PIN_OE_N == ~$past(FUNC_OE) &&
                                  STRAP_PIN_OUT == $past(FUNC_OUT)))
    else $error("strap pads not returned to function");

  a_status_read: assert property ((RD && ADDR == `STRAP_STATUS_OFF) |=>
                                  (RDATA == {27'h0000000, $past(strap_bits)}))
    else $error("status read mismatch");

  a_ldo_select: assert property ((!cfg_reg[`CFG_LDO_OVR_EN_BIT]) |=>
                                 (FLASH_VDD_1V8 == $past(strap_bits[`STRAP_LDO_BIT])))
    else $error("flash supply select wrong");

  a_boot_decode: assert property (s_held_two |=> (BOOT_MODE == (strap_bits[`STRAP_BOOT_BIT] ?
                                  BOOT_SPI : (strap_bits[`STRAP_QUAL_BIT] ? BOOT_UNDEFINED :
                                  BOOT_DOWNLOAD))))
    else $error("boot mode decode wrong");

  a_log_enable: assert property (##1 (BOOT_LOG_EN == $past(strap_bits[`STRAP_LOG_BIT])))
    else $error("boot log enable wrong");

  a_sdio_timing: assert property ((!cfg_reg[`CFG_SDIO_OVR_EN_BIT]) |=>
                                  ({SDIO_SAMPLE_RISE, SDIO_OUTPUT_RISE} ==
                                   {$past(strap_bits[`STRAP_LOG_BIT]),
                                    $past(strap_bits[`STRAP_SDIO_BIT])}))
    else $error("sdio timing select wrong");

  a_override_take: assert property ((phase_reg == PH_HELD && EN && WR &&
                                     ADDR == `STRAP_CONFIG_OFF &&
                                     WDATA[`CFG_LDO_OVR_EN_BIT]) |=> ##1
                                    (FLASH_VDD_1V8 == $past(WDATA[`CFG_LDO_1V8_BIT], 2)))
    else $error("flash supply override not applied");

  a_override_lock: assert property ((phase_reg == PH_TRACK) |=> (cfg_reg == `CFG_RESET))
    else $error("override accepted before boot");

  a_rdata_idle: assert property (!RD |=> (RDATA == 32'h00000000))
    else $error("read data not cleared after read cycle");

  a_valid_held: assert property ((phase_reg == PH_HELD) |=> STRAPS_VALID)
    else $error("straps valid missing while held");

  a_sdio_override: assert property ((phase_reg == PH_HELD && EN && WR &&
                                     ADDR == `STRAP_CONFIG_OFF &&
                                     WDATA[`CFG_SDIO_OVR_EN_BIT]) |=> ##1
                                    ({SDIO_SAMPLE_RISE, SDIO_OUTPUT_RISE} ==
                                     {$past(WDATA[`CFG_SDIO_SAMPLE_BIT], 2),
                                      $past(WDATA[`CFG_SDIO_OUTPUT_BIT], 2)}))
    else $error("sdio timing override not applied");

endmodule

`default_nettype wire

// ---- strap_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "strap_latch_params.svh"

module strap_host_model (
  input wire logic clk,             // System clock
  input wire logic [4:0] host_val,  // Levels the host or resistors impose
  input wire logic [4:0] host_oe,   // Host drive enables, high drives
  input wire logic [4:0] dev_out,   // Device pad outputs
  input wire logic [4:0] dev_oe_n,  // Device pad enables, low drives
  input wire logic [4:0] pull_en,   // Device weak pulls
  output logic [4:0] pin            // Resolved pad levels
);
  localparam logic [4:0] PULL_LEVEL = `STRAP_PULL_UP_MASK;
  logic [4:0] float_pat = 5'h15;

  // A pad nobody holds wanders, so a stale level cannot pass for a latch
  always @(posedge clk) float_pat <= ~float_pat;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!dev_oe_n[i]) pin[i] = dev_out[i];
      else if (host_oe[i]) pin[i] = host_val[i];
      else if (pull_en[i]) pin[i] = PULL_LEVEL[i];
      else pin[i] = float_pat[i];
    end
  end
endmodule

`default_nettype wire

// ---- test_reset_strap_config_latch.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "strap_latch_params.svh"

module test_reset_strap_config_latch
  import strap_latch_pkg::*;
;
  logic CLK, SRST, EN, WR, RD;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [4:0] PIN, POUT, OE_N, PULL, FOUT, FOE, FIN, hval, hoe;
  logic VALID, FLASH, LOG, SMP, OUTR;
  boot_mode_type BOOT_MODE;
  int errors = 0;
  int samples_checked = 0;
  logic [4:0] pats [4] = '{5'h00, 5'h1F, 5'h0C, 5'h13};

  reset_strap_config_latch DUT (.CLK(CLK), .SRST(SRST), .EN(EN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STRAP_PIN_IN(PIN), .STRAP_PIN_OUT(POUT),
    .STRAP_PIN_OE_N(OE_N), .STRAP_PULL_EN(PULL), .FUNC_OUT(FOUT), .FUNC_OE(FOE),
    .FUNC_IN(FIN), .STRAPS_VALID(VALID), .FLASH_VDD_1V8(FLASH), .BOOT_MODE(BOOT_MODE),
    .BOOT_LOG_EN(LOG), .SDIO_SAMPLE_RISE(SMP), .SDIO_OUTPUT_RISE(OUTR));

  strap_host_model host (.clk(CLK), .host_val(hval), .host_oe(hoe), .dev_out(POUT),
    .dev_oe_n(OE_N), .pull_en(PULL), .pin(PIN));

  initial begin
    CLK = 0;
    forever #5 CLK = ~CLK;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge CLK);
    WR <= 1'h0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CLK);
    RD <= 1'h0;
    #1 d = RDATA;
  endtask

  // Hold the chip in reset with given pad levels, then release it
  task automatic boot(input logic [4:0] v, input logic [4:0] oe);
    @(posedge CLK);
    EN <= 1'h0;
    hval <= v;
    hoe <= oe;
    repeat (3) @(posedge CLK);
    #1 check({27'h0, PULL}, 32'h1F);
    check({27'h0, OE_N}, 32'h1F);
    // Overrides must be refused while the straps still track
    bus_write(`STRAP_CONFIG_OFF, 32'h1F);
    @(posedge CLK);
    EN <= 1'h1;
    repeat (4) @(posedge CLK);
    #1;
  endtask

  task automatic expect_straps(input logic [4:0] p);
    boot_mode_type bm;
    bm = p[1] ? BOOT_SPI : (p[2] ? BOOT_UNDEFINED : BOOT_DOWNLOAD);
    check({31'h0, VALID}, 32'h1);
    check({31'h0, FLASH}, {31'h0, p[0]});
    check({30'h0, BOOT_MODE}, {30'h0, bm});
    check({31'h0, LOG}, {31'h0, p[3]});
    check({30'h0, SMP, OUTR}, {30'h0, p[3], p[4]});
    check({27'h0, PULL}, 32'h0);
    bus_read(`STRAP_STATUS_OFF, rd);
    check(rd, {27'h0, p});
    bus_read(`STRAP_EFFECT_OFF, rd);
    check(rd, {25'h0, 1'h1, p[4], p[3], p[3], bm, p[0]});
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge CLK);
    errors++;
    tally_and_finish;
  end

  initial begin
    SRST = 1'h1;
    EN = 1'h0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    WR = 1'h0;
    RD = 1'h0;
    FOUT = 5'h00;
    FOE = 5'h00;
    hval = 5'h00;
    hoe = 5'h00;
    repeat (20) @(posedge CLK);
    SRST <= 1'h0;
    boot(5'h00, 5'h00);
    expect_straps(`STRAP_PULL_UP_MASK);
    for (int k = 0; k < 4; k++) begin
      boot(pats[k], 5'h1F);
      expect_straps(pats[k]);
      @(posedge CLK);
      hval <= ~pats[k];
      repeat (2) @(posedge CLK);
      bus_read(`STRAP_STATUS_OFF, rd);
      check(rd, {27'h0, pats[k]});
    end
    // Override drops flash to 3.3 V against a 1.8 V strap
    bus_write(`STRAP_CONFIG_OFF, 32'h0D);
    bus_write(`STRAP_STATUS_OFF, 32'h0);
    repeat (3) @(posedge CLK);
    #1 check({29'h0, FLASH, SMP, OUTR}, 32'h2);
    bus_read(`STRAP_CONFIG_OFF, rd);
    check(rd, 32'h0D);
    bus_read(`STRAP_STATUS_OFF, rd);
    check(rd, 32'h13);
    @(posedge CLK);
    #1 check(RDATA, 32'h0);
    bus_read(8'h0C, rd);
    check(rd, 32'h0);
    @(posedge CLK);
    FOE <= 5'h0F;
    FOUT <= 5'h05;
    hoe <= 5'h10;
    hval <= 5'h10;
    repeat (4) @(posedge CLK);
    #1 check({27'h0, OE_N}, 32'h10);
    check({27'h0, POUT & 5'h0F}, 32'h05);
    check({27'h0, FIN}, 32'h15);
    bus_read(`STRAP_STATUS_OFF, rd);
    check(rd, 32'h13);
    tally_and_finish;
  end
endmodule

`default_nettype wire
